// ---- design/asq_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 15 of each step register includes the step in the sequence when 1, resets to 0.
// - Bits 14:13 give gain 1 for 00, 2 for 01 and 4 for 10 or 11, reset 00.
// - Bits 12:5 are reserved and always read zero whatever is written.
// - Bit 4 picks the negative input, 0 analog ground and 1 external input seven, reset 0.
// - Bits 3:0 pick the positive input, codes 0 to 7 being external inputs 0 to 7.
// - Positive codes from 8 upward route internal sources such as sensor, short, test DAC, monitors.
// - For the auto-selecting positive codes the negative input is chosen internally, bit 4 ignored.
// - The step 2 register sits at index 92h and resets to 0002h.
// - The step 1 register resets with positive select 0001 and all other fields zero.
module asq_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire asq_pkg::asq_addr_t s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire asq_pkg::asq_data_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire asq_pkg::asq_addr_t s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output asq_pkg::asq_data_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Converter side
    output logic conv_start,
    input wire logic conv_done,
    output logic [2:0] conv_gain,
    output logic [3:0] conv_pos_sel,
    output logic [1:0] conv_neg_sel,
    output logic conv_step
);
    import asq_pkg::*;

    logic aw_held_reg;
    logic w_held_reg;
    asq_addr_t aw_addr_reg;
    asq_data_t w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_do;
    logic wr_hit;
    logic run_reg;
    asq_state_t state_reg;
    logic cur_reg;
    logic ptr_reg;
    logic next_sel;
    asq_cfg_t cfg [NSTEP];
    logic [NSTEP-1:0] incl;
    logic [NSTEP-1:0] step_wr;
    logic [NSTEP-1:0] step_was_rd_reg;

    // Write fires once both halves are held and the previous answer is gone
    assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;

    genvar gi;
    generate
        for (gi = 0; gi < NSTEP; gi++) begin : g_step
            localparam asq_cfg_t RV = (gi == 0) ? STEP1_RST : STEP2_RST;
            localparam logic [9:0] IX = (gi == 0) ? STEP1_IDX : STEP2_IDX;
            assign step_wr[gi] = wr_do && (aw_addr_reg[11:2] == IX);
            assign incl[gi] = cfg[gi][INCL_BIT];
            asq_step_reg #(.RST_VAL(RV)) u_step (
                .clk(clk),
                .nrst(nrst),
                .wr_en(step_wr[gi]),
                .be(w_strb_reg[1:0]),
                .wdata(w_data_reg[15:0]),
                .cfg(cfg[gi])
            );
        end
    endgenerate

    assign wr_hit = (aw_addr_reg[11:2] == STEP1_IDX)
        || (aw_addr_reg[11:2] == STEP2_IDX)
        || (aw_addr_reg[11:2] == CTRL_IDX)
        || (aw_addr_reg[11:2] == STAT_IDX);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_do) begin
            aw_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_do) begin
            w_held_reg <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_reg <= CTRL_RUN_RST;
        end else if (wr_do && w_strb_reg[0]
                && aw_addr_reg[11:2] == CTRL_IDX) begin
            run_reg <= w_data_reg[CTRL_RUN_BIT];
        end
    end

    // Reads answer one cycle after the address is taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            step_was_rd_reg <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            step_was_rd_reg <= '0;
            case (s_axi_araddr[11:2])
                STEP1_IDX: begin
                    s_axi_rdata <= {16'h0000, cfg[0]};
                    step_was_rd_reg <= 2'b01;
                end
                STEP2_IDX: begin
                    s_axi_rdata <= {16'h0000, cfg[1]};
                    step_was_rd_reg <= 2'b10;
                end
                CTRL_IDX: begin
                    s_axi_rdata <= {31'h00000000, run_reg};
                end
                STAT_IDX: begin
                    s_axi_rdata <= {29'h00000000, conv_start,
                        cur_reg, state_reg != SEQ_IDLE};
                end
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Next enabled step at or after the pointer, wrapping past the end
    assign next_sel = incl[ptr_reg] ? ptr_reg : !ptr_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SEQ_IDLE;
            cur_reg <= 1'b0;
            ptr_reg <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (state_reg)
                SEQ_IDLE: begin
                    if (run_reg && (incl != '0)) begin
                        cur_reg <= next_sel;
                        state_reg <= SEQ_APPLY;
                    end
                end
                SEQ_APPLY: begin
                    conv_start <= 1'b1;
                    state_reg <= SEQ_CONV;
                end
                SEQ_CONV: begin
                    if (conv_done) begin
                        ptr_reg <= !cur_reg;
                        state_reg <= SEQ_IDLE;
                    end
                end
                default: begin
                    state_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Settings land one cycle ahead of the start pulse so the mux settles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_gain <= GAIN_X1;
            conv_pos_sel <= STEP1_RST[POS_HI:0];
            conv_neg_sel <= NEG_GND;
            conv_step <= 1'b0;
        end else if (state_reg == SEQ_IDLE && run_reg && (incl != '0)) begin
            conv_step <= next_sel;
            case (cfg[next_sel][GAIN_HI:GAIN_LO])
                GAIN_C1: conv_gain <= GAIN_X1;
                GAIN_C2: conv_gain <= GAIN_X2;
                default: conv_gain <= GAIN_X4;
            endcase
            // Internal sources keep codes 8..15 untouched for the mux
            conv_pos_sel <= cfg[next_sel][POS_HI:0];
            if (cfg[next_sel][POS_AUTO_BIT]) begin
                conv_neg_sel <= NEG_AUTO;
            end else if (cfg[next_sel][NEG_BIT]) begin
                conv_neg_sel <= NEG_EXT7;
            end else begin
                conv_neg_sel <= NEG_GND;
            end
        end
    end

    rst_step2_a: assert property (@(posedge clk)
        $rose(nrst) |-> cfg[1] == STEP2_RST)
        else $error("step 2 reset value wrong");
    rst_step1_a: assert property (@(posedge clk)
        $rose(nrst) |-> cfg[0] == STEP1_RST)
        else $error("step 1 reset value wrong");
    rd_rsv_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        s_axi_rvalid && (step_was_rd_reg != '0)
            |-> s_axi_rdata[RSV_HI:RSV_LO] == 8'h00)
        else $error("reserved step bits read nonzero");
    start_enab_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(conv_start) |-> incl[conv_step] || $past(incl[conv_step]))
        else $error("disabled step was converted");
    // Settings come from the step now shown, as stored one cycle back
    gain_map_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == SEQ_APPLY |-> conv_gain ==
            ((conv_step ? $past(cfg[1][GAIN_HI]) : $past(cfg[0][GAIN_HI]))
                ? GAIN_X4
                : ((conv_step ? $past(cfg[1][GAIN_LO])
                    : $past(cfg[0][GAIN_LO])) ? GAIN_X2 : GAIN_X1)))
        else $error("gain factor does not match code");
    neg_auto_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == SEQ_APPLY && conv_pos_sel[POS_AUTO_BIT]
            |-> conv_neg_sel == NEG_AUTO)
        else $error("auto negative input not chosen");
    neg_pick_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == SEQ_APPLY && !conv_pos_sel[POS_AUTO_BIT]
            |-> conv_neg_sel == {1'b0, (conv_step ? $past(cfg[1][NEG_BIT])
                : $past(cfg[0][NEG_BIT]))})
        else $error("negative input select not honoured");
    pos_route_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == SEQ_APPLY
            |-> conv_pos_sel == (conv_step ? $past(cfg[1][POS_HI:0])
                : $past(cfg[0][POS_HI:0])))
        else $error("positive select not applied");
    seq_order_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == SEQ_CONV && conv_done && (incl == 2'b11)
            ##1 state_reg == SEQ_IDLE && run_reg
            |=> conv_step != $past(conv_step, 2))
        else $error("sequencer did not advance to next step");
    apply_then_go_a: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == SEQ_APPLY |=> conv_start ##1 !conv_start)
        else $error("start pulse missing after apply");

    // Bus answers hold until taken; refused writes leave steps alone
    bresp_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before taken");
    rdata_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata)
                && $stable(s_axi_rresp))
        else $error("read answer dropped before taken");
    bad_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_do && !wr_hit |=> s_axi_bresp == RESP_SLVERR
            && $stable(cfg[0]) && $stable(cfg[1]))
        else $error("unmapped write not refused");
    rd_step1_a: assert property (
        @(posedge clk) disable iff (!nrst)
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == STEP1_IDX
            |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(cfg[0])})
        else $error("step 1 read data wrong");
    rd_step2_a: assert property (
        @(posedge clk) disable iff (!nrst)
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == STEP2_IDX
            |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(cfg[1])})
        else $error("step 2 read data wrong");
    pos_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        step_wr[1] && w_strb_reg[0]
            |=> cfg[1][POS_HI:0] == $past(w_data_reg[POS_HI:0]))
        else $error("positive select write lost");
    neg_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        step_wr[0] && w_strb_reg[0]
            |=> cfg[0][NEG_BIT] == $past(w_data_reg[NEG_BIT]))
        else $error("negative select write lost");
    gain_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        step_wr[1] && w_strb_reg[1]
            |=> cfg[1][GAIN_HI:GAIN_LO]
                == $past(w_data_reg[GAIN_HI:GAIN_LO]))
        else $error("gain code write lost");
    idle_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == SEQ_IDLE && !(run_reg && (incl != '0))
            |=> state_reg == SEQ_IDLE && !conv_start)
        else $error("sequencer left idle with nothing to do");
    conv_wait_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == SEQ_CONV && !conv_done |=> state_reg == SEQ_CONV)
        else $error("conversion left before done");
    start_once_a: assert property (
        @(posedge clk) disable iff (!nrst)
        conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    settle_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == SEQ_CONV |-> $stable(conv_gain) && $stable(conv_step)
            && $stable(conv_pos_sel) && $stable(conv_neg_sel))
        else $error("settings moved during conversion");
    rst_outs_a: assert property (
        @(posedge clk)
        $rose(nrst) |-> !conv_start && conv_gain == GAIN_X1
            && conv_pos_sel == STEP1_RST[POS_HI:0]
            && conv_neg_sel == NEG_GND && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not at reset values");
endmodule

// ---- design/asq_pkg.sv ----
package asq_pkg;
    typedef logic [11:0] asq_addr_t;
    typedef logic [31:0] asq_data_t;
    typedef logic [15:0] asq_cfg_t;
    // Register indices; byte address is four times the index
    localparam logic [9:0] STEP1_IDX = 10'h091;
    localparam logic [9:0] STEP2_IDX = 10'h092;
    localparam logic [9:0] CTRL_IDX = 10'h098;
    localparam logic [9:0] STAT_IDX = 10'h099;
    localparam asq_addr_t STEP1_ADDR = {STEP1_IDX, 2'b00};
    localparam asq_addr_t STEP2_ADDR = {STEP2_IDX, 2'b00};
    localparam asq_addr_t CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam asq_addr_t STAT_ADDR = {STAT_IDX, 2'b00};
    // Reset values
    localparam asq_cfg_t STEP1_RST = 16'h0001;
    localparam asq_cfg_t STEP2_RST = 16'h0002;
    localparam logic CTRL_RUN_RST = 1'b0;
    // Step register fields
    localparam int INCL_BIT = 15;
    localparam int GAIN_HI = 14;
    localparam int GAIN_LO = 13;
    localparam int RSV_HI = 12;
    localparam int RSV_LO = 5;
    localparam int NEG_BIT = 4;
    localparam int POS_HI = 3;
    localparam int POS_AUTO_BIT = 3;
    // Control and status fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_STEP_BIT = 1;
    localparam int STAT_CONV_BIT = 2;
    // Gain codes and factors
    localparam logic [1:0] GAIN_C1 = 2'h0;
    localparam logic [1:0] GAIN_C2 = 2'h1;
    localparam logic [2:0] GAIN_X1 = 3'h1;
    localparam logic [2:0] GAIN_X2 = 3'h2;
    localparam logic [2:0] GAIN_X4 = 3'h4;
    // Negative input routing
    localparam logic [1:0] NEG_GND = 2'h0;
    localparam logic [1:0] NEG_EXT7 = 2'h1;
    localparam logic [1:0] NEG_AUTO = 2'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int NSTEP = 2;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_APPLY = 3'b010,
        SEQ_CONV = 3'b100
    } asq_state_t;
endpackage

// ---- design/asq_step_reg.sv ----
`timescale 1ns/1ps
module asq_step_reg #(
    parameter asq_pkg::asq_cfg_t RST_VAL = 16'h0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Write port
    input wire logic wr_en,
    input wire logic [1:0] be,
    input wire asq_pkg::asq_cfg_t wdata,
    // Stored configuration
    output asq_pkg::asq_cfg_t cfg
);
    import asq_pkg::*;
    logic incl_reg;
    logic [1:0] gain_reg;
    logic neg_reg;
    logic [3:0] pos_reg;

    // Reserved bits are not stored, so they cannot read back nonzero
    assign cfg = {incl_reg, gain_reg, 8'h00, neg_reg, pos_reg};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            incl_reg <= RST_VAL[INCL_BIT];
            gain_reg <= RST_VAL[GAIN_HI:GAIN_LO];
        end else if (wr_en && be[1]) begin
            incl_reg <= wdata[INCL_BIT];
            gain_reg <= wdata[GAIN_HI:GAIN_LO];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            neg_reg <= RST_VAL[NEG_BIT];
            pos_reg <= RST_VAL[POS_HI:0];
        end else if (wr_en && be[0]) begin
            neg_reg <= wdata[NEG_BIT];
            pos_reg <= wdata[POS_HI:0];
        end
    end

    incl_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_en && be[1] |=> cfg[INCL_BIT] == $past(wdata[INCL_BIT]))
        else $error("include bit did not take written value");
    hold_nowr_a: assert property (@(posedge clk) disable iff (!nrst)
        !wr_en |=> $stable(cfg))
        else $error("step config changed without a write");
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import asq_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic conv_done = 1'b0;
    asq_addr_t s_axi_awaddr = '0;
    asq_addr_t s_axi_araddr = '0;
    asq_data_t s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, conv_start, conv_step;
    logic [1:0] s_axi_bresp, s_axi_rresp, conv_neg_sel;
    asq_data_t s_axi_rdata;
    logic [2:0] conv_gain;
    logic [3:0] conv_pos_sel;
    int fail_count = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    asq_top dut (.clk(clk), .nrst(nrst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .conv_start(conv_start),
        .conv_done(conv_done), .conv_gain(conv_gain),
        .conv_pos_sel(conv_pos_sel), .conv_neg_sel(conv_neg_sel),
        .conv_step(conv_step));

    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // Called just after a rising edge; returns just after one
    task automatic axi_write(input asq_addr_t a, input asq_data_t d,
                             input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        chk(32'(s_axi_bvalid), 32'h1, "write answer");
        chk(32'(s_axi_bresp), 32'(er), "write resp");
    endtask

    task automatic axi_read(input asq_addr_t a, input asq_data_t ed,
                            input logic [1:0] er);
        int n;
        n = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        chk(32'(s_axi_rvalid), 32'h1, "read answer");
        chk(s_axi_rdata, ed, "read data");
        chk(32'(s_axi_rresp), 32'(er), "read resp");
    endtask

    // Settings are sampled at the edge that sees the start pulse
    task automatic wait_start(input logic es, input logic [2:0] eg,
                              input logic [3:0] ep, input logic [1:0] en);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (conv_start !== 1'b1 && n < 20);
        chk(32'(conv_start), 32'h1, "start pulse");
        chk(32'(conv_step), 32'(es), "conv step");
        chk(32'(conv_gain), 32'(eg), "conv gain");
        chk(32'(conv_pos_sel), 32'(ep), "conv pos");
        chk(32'(conv_neg_sel), 32'(en), "conv neg");
        @(posedge clk);
        chk(32'(conv_start), 32'h0, "start one cycle");
    endtask

    task automatic pulse_done();
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        logic [4:0] i;
        logic [2:0] eg;
        logic [1:0] en;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(32'(conv_pos_sel), 32'h1, "reset pos");
        chk(32'(conv_gain), 32'(GAIN_X1), "reset gain");
        chk(32'(conv_neg_sel), 32'(NEG_GND), "reset neg");
        axi_read(STEP1_ADDR, 32'h0000_0001, RESP_OKAY);
        axi_read(STEP2_ADDR, 32'h0000_0002, RESP_OKAY);
        axi_write(STEP1_ADDR, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        axi_read(STEP1_ADDR, 32'h0000_E01F, RESP_OKAY);
        axi_write(STEP2_ADDR, 32'h0000_A5C3, 4'h1, RESP_OKAY);
        axi_read(STEP2_ADDR, 32'h0000_0003, RESP_OKAY);
        axi_write(STEP2_ADDR, 32'h0000_A500, 4'h2, RESP_OKAY);
        axi_read(STEP2_ADDR, 32'h0000_A003, RESP_OKAY);
        // Unmapped place must leave stored steps alone
        axi_write(12'h100, 32'h0000_FFFF, 4'hF, RESP_SLVERR);
        axi_read(12'h100, 32'h0000_0000, RESP_SLVERR);
        axi_write(STAT_ADDR, 32'h0000_0007, 4'hF, RESP_OKAY);
        axi_read(STEP1_ADDR, 32'h0000_E01F, RESP_OKAY);
        axi_write(STEP2_ADDR, 32'h0000_0002, 4'hF, RESP_OKAY);
        // Every positive code with a rotating gain code and negative bit
        for (i = 5'd0; i < 5'd16; i++) begin
            eg = (i[1:0] == 2'd0) ? GAIN_X1 :
                 (i[1:0] == 2'd1) ? GAIN_X2 : GAIN_X4;
            en = i[3] ? NEG_AUTO : (i[1] ? NEG_EXT7 : NEG_GND);
            axi_write(STEP1_ADDR, {16'h0, 1'b1, i[1:0], 8'h00, i[1], i[3:0]},
                      4'hF, RESP_OKAY);
            axi_write(CTRL_ADDR, 32'h1, 4'hF, RESP_OKAY);
            wait_start(1'b0, eg, i[3:0], en);
            // Stop before done so the next code is picked up fresh
            axi_write(CTRL_ADDR, 32'h0, 4'hF, RESP_OKAY);
            pulse_done();
        end
        // Both steps included: ascending with wrap; the loop left the
        // pointer on step 2, so the run resumes there
        axi_write(STEP1_ADDR, 32'h0000_8004, 4'hF, RESP_OKAY);
        axi_write(STEP2_ADDR, 32'h0000_A018, 4'hF, RESP_OKAY);
        axi_write(CTRL_ADDR, 32'h1, 4'hF, RESP_OKAY);
        wait_start(1'b1, GAIN_X2, 4'h8, NEG_AUTO);
        axi_read(STAT_ADDR, 32'h0000_0003, RESP_OKAY);
        pulse_done();
        wait_start(1'b0, GAIN_X1, 4'h4, NEG_GND);
        pulse_done();
        wait_start(1'b1, GAIN_X2, 4'h8, NEG_AUTO);
        // Excluded step 1 must be skipped
        axi_write(STEP1_ADDR, 32'h0000_0004, 4'hF, RESP_OKAY);
        pulse_done();
        wait_start(1'b1, GAIN_X2, 4'h8, NEG_AUTO);
        pulse_done();
        wait_start(1'b1, GAIN_X2, 4'h8, NEG_AUTO);
        axi_read(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
        axi_write(CTRL_ADDR, 32'h0, 4'hF, RESP_OKAY);
        axi_read(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
        pulse_done();
        end_sim();
    end

    initial begin
        #200us;
        fail_count++;
        end_sim();
    end
endmodule
